// >>> common/mcd_pkg.sv
// constants, field layouts and carrier types of the commutation delay manager
// assumes one 125 MHz clock and an axi4-lite register bus with 32-bit data
`default_nettype none

package mcd_pkg;

   // ********
   // register map (byte addresses) and field positions
   // ********
   localparam logic [5:0] OFS_PIN = 6'h00;
   localparam logic [5:0] OFS_MODE = 6'h04;
   localparam logic [5:0] OFS_PHASE = 6'h08;
   localparam logic [5:0] OFS_RATIO = 6'h0C;
   localparam logic [5:0] OFS_COMP = 6'h10;
   localparam logic [5:0] OFS_DEMAG = 6'h14;
   localparam logic [5:0] OFS_ZC = 6'h18;
   localparam logic [5:0] OFS_ZPRV = 6'h1C;
   localparam logic [5:0] OFS_WGHT = 6'h20;
   localparam logic [5:0] OFS_TIMER = 6'h24;
   localparam logic [5:0] OFS_STATUS = 6'h28;

   // pin configuration register
   localparam int unsigned PIN_PCN = 0;
   localparam int unsigned PIN_TES = 1;
   localparam int unsigned PIN_SR = 3;
   localparam int unsigned PIN_IS = 4;
   localparam int unsigned PIN_OFF_INPUT_GROUND_SELECT = 6;
   localparam int unsigned PIN_RUN = 7;

   // input select codes
   localparam logic [1:0] SEL_A = 2'h0;
   localparam logic [1:0] SEL_B = 2'h1;
   localparam logic [1:0] SEL_C = 2'h2;
   localparam logic [1:0] SEL_NONE = 2'h3;

   // axi response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ********
   // carrier types
   // ********
   // mode preload, low six bits of the mode register in this order
   typedef struct packed {
      logic sim_demag;
      logic sim_zero;
      logic direct;
      logic soft_comm;
      logic dcb;
      logic autosw;
   } mcd_mode_s;

   // one bit per phase input, bit 0 is a, bit 2 is c
   typedef struct packed {
      logic [2:0] analog_sel;
      logic [2:0] digital_sel;
      logic [2:0] std_io;
      logic [2:0] ground_en;
      logic [2:0] read_en;
      logic comp_on;
      logic speed_mode;
   } mcd_pins_s;

   typedef struct packed {
      logic comm;
      logic demag;
      logic zero;
   } mcd_events_s;

   // whole state of the top module
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic aw_have;
      logic w_have;
      logic [5:0] aw_addr;
      logic [7:0] w_byte;
      logic w_lane0;
      logic [7:0] pin_cfg;
      mcd_mode_s mode_pre;
      mcd_mode_s mode_act;
      logic [5:0] phase_pre;
      logic [5:0] phase_act;
      logic [3:0] ratio;
      logic [14:0] pre_cnt;
      logic [7:0] timer;
      logic [7:0] comp;
      logic [7:0] demag;
      logic [7:0] zc;
      logic [7:0] zprv;
      logic [7:0] wght;
      logic comp_armed;
      logic demag_armed;
      logic zc_armed;
      logic mult_load;
      mcd_pins_s pins;
      mcd_events_s ev;
   } mcd_state_s;

   localparam mcd_state_s STATE_RST = '0;

endpackage

`default_nettype wire

// >>> core/mcd_mult.sv
// weighted commutation delay: a times b divided by 256
// purely combinational; the caller registers the result
`default_nettype none

module mcd_mult #(
   parameter int unsigned WIDTH = 8
) (
   // operands
   input wire logic [WIDTH-1:0] weight,
   input wire logic [WIDTH-1:0] interval,
   // scaled product
   output logic [WIDTH-1:0] delay
);

   // ************************************************************
   // elaboration check
   // ************************************************************
   if (WIDTH < 2) begin : g_bad_width
      $error("mcd_mult: WIDTH must be at least 2");
   end

   logic [2*WIDTH-1:0] product;

   // full product, upper half is the divide by 2**WIDTH
   assign product = weight * interval;
   assign delay = product[2*WIDTH-1:WIDTH];

endmodule

`default_nettype wire

// >>> core/mcd_top.sv
// commutation delay manager with phase-input pin configuration
// assumes an axi4-lite master, synchronous single-cycle event pulses
// from the input detection block, and one clock with async reset
//
// Function
// - sensor mode routes selected input to comparator
// - sensor mode select 11 frees all inputs
// - edge select nonzero gives tacho or encoder inputs; here only in sensor mode, else all plain i/o
// - sensorless off inputs float or ground
// - analog inputs lose their digital path
// - digital sensor inputs stay readable on port
// - eight-bit timer with shifting prescaler
// - capture and compare registers update on events
// - preload bits apply at commutation or phase write
// - demag register captures and simulates demag
// - two cascaded zero-cross captures, current also compares
// - multiplier computes next commutation time
// - commutation when timer matches compare register
// - autoswitched mode commutates automatically
// - soft commutation on timer match of written compare
// - soft compare armed only by compare write
// - nonzero edge select measures speed only
// - speed mode leaves six-step logic idle
// - autoswitch bit selects autoswitched or switched
// - switched mode match commutates and clears timer
// - hardware zero cross captures, shifts, clears timer in autoswitched or speed mode
//
// Chosen here: the address map and the AXI4-Lite register port.
`default_nettype none

module mcd_top #(
   parameter int unsigned ADDR_W = 6,
   parameter int unsigned TIMER_W = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // axi4-lite write address and data
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // events from the input detection block
   input wire logic zero_cross_in,
   input wire logic demag_in,
   // pin configuration, events and phase state out
   output mcd_pkg::mcd_pins_s pins,
   output mcd_pkg::mcd_events_s events,
   output logic [5:0] phase_state
);

   // ********
   // elaboration checks
   // ********
   if (ADDR_W < 6) begin : g_bad_addr
      $error("mcd_top: ADDR_W must be at least 6");
   end
   if (TIMER_W != 8) begin : g_bad_timer
      $error("mcd_top: only an 8-bit timer is supported");
   end

   // ********
   // functions
   // ********
   // address decode shared by the read and the write path
   function automatic logic mcd_mapped(input logic [ADDR_W-1:0] addr);
      logic hit;
      hit = 1'b0;
      if (addr[ADDR_W-1:2] <= (ADDR_W-2)'(mcd_pkg::OFS_STATUS[5:2])) begin
         hit = 1'b1;
      end
      return hit;
   endfunction

   // phase input routing from the pin configuration byte
   function automatic mcd_pkg::mcd_pins_s mcd_pin_decode(
      input logic [7:0] cfg);
      mcd_pkg::mcd_pins_s p;
      logic position_sensor_select;
      logic [1:0] speed_sensor_edge_select;
      logic [1:0] sel;
      logic [2:0] onehot;
      p = '0;
      position_sensor_select = cfg[mcd_pkg::PIN_PCN];
      speed_sensor_edge_select = cfg[mcd_pkg::PIN_TES +: 2];
      sel = cfg[mcd_pkg::PIN_IS +: 2];
      onehot = (sel == mcd_pkg::SEL_NONE) ? 3'h0 : 3'(3'h1 << sel);
      p.speed_mode = (speed_sensor_edge_select != 2'h0);
      if (!position_sensor_select && speed_sensor_edge_select == 2'h0) begin
         // sensorless: off inputs follow the grounding select
         p.analog_sel = onehot;
         p.ground_en = cfg[mcd_pkg::PIN_OFF_INPUT_GROUND_SELECT] ? ~onehot : 3'h0;
         p.comp_on = (sel != mcd_pkg::SEL_NONE);
      end else if (position_sensor_select && speed_sensor_edge_select == 2'h0) begin
         p.analog_sel = onehot;
         p.std_io = ~onehot;
         p.comp_on = (sel != mcd_pkg::SEL_NONE);
      end else if (position_sensor_select) begin
         // speed sensors: comparator always off
         p.digital_sel = (sel == mcd_pkg::SEL_NONE) ? 3'h3 : onehot;
         p.std_io = ~p.digital_sel;
      end else begin
         // combination not defined: leave every input as plain i/o
         p.std_io = 3'h7;
      end
      // analog inputs lose the port path, digital ones keep it
      p.read_en = p.std_io | p.digital_sel;
      return p;
   endfunction

   // ********
   // state and multiplier
   // ********
   mcd_pkg::mcd_state_s s_q;
   mcd_pkg::mcd_state_s s_d;
   logic [7:0] mult_res;

   // the multiplier reads registered captures, so its result is
   // used one cycle after the shift that it depends on
   mcd_mult #(
      .WIDTH(TIMER_W)
   ) u_mult (
      .weight(s_q.wght),
      .interval(s_q.mode_act.dcb ? s_q.zc : s_q.zprv),
      .delay(mult_res)
   );

   // ********
   // next-state logic
   // ********
   always_comb begin
      logic run;
      logic tick;
      logic six_step;
      logic cmp_en;
      logic hw_z;
      logic sim_z;
      logic hw_d;
      logic sim_d;
      logic comm;
      logic wr_go;
      logic phase_wr;
      logic [14:0] mask;
      logic [7:0] nxt;
      logic [7:0] rd;
      s_d = s_q;
      s_d.ev = '0;
      run = s_q.pin_cfg[mcd_pkg::PIN_RUN];
      mask = 15'(16'h0001 << s_q.ratio) - 15'h0001;
      tick = run && (s_q.pre_cnt >= mask);
      nxt = s_q.timer + 8'h01;
      six_step = !s_q.pins.speed_mode;
      comm = 1'b0;
      wr_go = 1'b0;
      phase_wr = 1'b0;
      rd = 8'h00;

      // prescaler: one timer step per 2**ratio clocks
      if (run) begin
         s_d.pre_cnt = tick ? 15'h0000 : s_q.pre_cnt + 15'h0001;
      end else begin
         s_d.pre_cnt = 15'h0000;
      end

      // hardware events only count while the timer runs
      hw_z = run && zero_cross_in;
      hw_d = run && demag_in;
      sim_z = tick && s_q.mode_act.sim_zero && s_q.zc_armed &&
         nxt == s_q.zc;
      sim_d = tick && s_q.mode_act.sim_demag && s_q.demag_armed &&
         nxt == s_q.demag;

      // compare enable: switched without soft commutation compares
      // always; soft and autoswitched need an arming load first
      if (!s_q.mode_act.autosw && !s_q.mode_act.soft_comm) begin
         cmp_en = 1'b1;
      end else begin
         cmp_en = s_q.comp_armed;
      end
      if (six_step && tick && cmp_en && nxt == s_q.comp) begin
         comm = 1'b1;
         s_d.comp_armed = 1'b0;
      end

      // autoswitched hardware commutation: load the weighted delay,
      // firing at once if the timer has already passed it
      s_d.mult_load = 1'b0;
      if (s_q.mult_load && six_step) begin
         if (mult_res <= s_q.timer) begin
            comm = 1'b1;
            s_d.comp = s_q.timer;
            s_d.comp_armed = 1'b0;
         end else begin
            s_d.comp = mult_res;
            s_d.comp_armed = 1'b1;
         end
      end

      // demagnetization capture and simulated demag
      if (hw_d) begin
         s_d.demag = s_q.timer;
      end
      if (sim_d) begin
         s_d.demag_armed = 1'b0;
      end

      // zero crossing: cascade the captures; the count restarts only in autoswitched and speed modes
      if (hw_z) begin
         s_d.zc = s_q.timer;
         s_d.zprv = s_q.zc;
      end else if (sim_z) begin
         s_d.zprv = s_q.zc;
         s_d.zc_armed = 1'b0;
      end
      if ((hw_z || sim_z) && s_q.mode_act.autosw && six_step &&
         !s_q.mode_act.soft_comm) begin
         s_d.mult_load = 1'b1;
      end

      // timer: zero cross clears it in autoswitched and speed modes,
      // a switched-mode commutation clears it, else it steps
      if (!run) begin
         s_d.timer = s_q.timer;
      end else if ((hw_z || sim_z) &&
         (s_q.mode_act.autosw || !six_step)) begin
         s_d.timer = 8'h00;
      end else if (comm && !s_q.mode_act.autosw) begin
         s_d.timer = 8'h00;
      end else if (tick) begin
         s_d.timer = nxt;
      end

      // events leave as single-cycle pulses
      s_d.ev.comm = comm;
      s_d.ev.demag = hw_d || sim_d;
      s_d.ev.zero = hw_z || sim_z;

      // ********
      // axi4-lite write channel
      // ********
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_axi_awvalid && s_q.awready) begin
         s_d.aw_have = 1'b1;
         s_d.aw_addr = s_axi_awaddr[5:0];
      end
      if (s_axi_wvalid && s_q.wready) begin
         s_d.w_have = 1'b1;
         s_d.w_byte = s_axi_wdata[7:0];
         s_d.w_lane0 = s_axi_wstrb[0];
      end
      // both halves held: perform the write and answer next cycle
      if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = mcd_mapped(ADDR_W'(s_q.aw_addr)) ?
            mcd_pkg::RESP_OKAY : mcd_pkg::RESP_SLVERR;
         wr_go = s_q.w_lane0;
      end

      // register writes come after the hardware updates so that a
      // write arming a compare wins over a same-cycle disarm
      if (wr_go) begin
         unique case (s_q.aw_addr)
            mcd_pkg::OFS_PIN: s_d.pin_cfg = s_q.w_byte;
            mcd_pkg::OFS_MODE: s_d.mode_pre = s_q.w_byte[5:0];
            mcd_pkg::OFS_PHASE: begin
               s_d.phase_pre = s_q.w_byte[5:0];
               phase_wr = 1'b1;
            end
            mcd_pkg::OFS_RATIO: s_d.ratio = s_q.w_byte[3:0];
            mcd_pkg::OFS_COMP: begin
               s_d.comp = s_q.w_byte;
               s_d.comp_armed = 1'b1;
            end
            mcd_pkg::OFS_DEMAG: begin
               s_d.demag = s_q.w_byte;
               s_d.demag_armed = 1'b1;
            end
            mcd_pkg::OFS_ZC: begin
               s_d.zc = s_q.w_byte;
               s_d.zc_armed = 1'b1;
            end
            mcd_pkg::OFS_WGHT: s_d.wght = s_q.w_byte;
            default: ;
         endcase
      end

      // preload: at commutation normally, at a phase write in direct
      // access mode, and freely while the timer is stopped
      if ((comm && !s_q.mode_act.direct) ||
         (phase_wr && s_q.mode_act.direct) || !run) begin
         s_d.mode_act = s_d.mode_pre;
         s_d.phase_act = s_d.phase_pre;
      end

      // ********
      // axi4-lite read channel
      // ********
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_q.arready) begin
         unique case (s_axi_araddr[5:0])
            mcd_pkg::OFS_PIN: rd = s_q.pin_cfg;
            mcd_pkg::OFS_MODE: rd = {2'h0, s_q.mode_pre};
            mcd_pkg::OFS_PHASE: rd = {2'h0, s_q.phase_act};
            mcd_pkg::OFS_RATIO: rd = {4'h0, s_q.ratio};
            mcd_pkg::OFS_COMP: rd = s_q.comp;
            mcd_pkg::OFS_DEMAG: rd = s_q.demag;
            mcd_pkg::OFS_ZC: rd = s_q.zc;
            mcd_pkg::OFS_ZPRV: rd = s_q.zprv;
            mcd_pkg::OFS_WGHT: rd = s_q.wght;
            mcd_pkg::OFS_TIMER: rd = s_q.timer;
            mcd_pkg::OFS_STATUS: rd = {2'h0, s_q.pins.speed_mode,
               s_q.pins.comp_on, s_q.mult_load, s_q.zc_armed,
               s_q.demag_armed, s_q.comp_armed};
            default: rd = 8'h00;
         endcase
         s_d.rvalid = 1'b1;
         s_d.rdata = {24'h00_0000, rd};
         s_d.rresp = mcd_mapped(s_axi_araddr) ?
            mcd_pkg::RESP_OKAY : mcd_pkg::RESP_SLVERR;
      end

      // ready flags are registered so outputs come from flip-flops
      s_d.awready = !s_d.aw_have && !s_d.bvalid;
      s_d.wready = !s_d.w_have && !s_d.bvalid;
      s_d.arready = !s_d.rvalid;

      // pin routing follows the configuration byte one cycle later
      s_d.pins = mcd_pin_decode(s_q.pin_cfg);
   end

   // ********
   // state register
   // ********
   // everything, timer and captures included, clears on reset
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         s_q <= mcd_pkg::STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ********
   // outputs
   // ********
   assign s_axi_awready = s_q.awready;
   assign s_axi_wready = s_q.wready;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign pins = s_q.pins;
   assign events = s_q.ev;
   assign phase_state = s_q.phase_act;

endmodule

`default_nettype wire

// >>> verification/mcd_top_sva.sv
// checker for the delay manager top level, bound to every instance
// assumes it sees only the top ports, one clock and async high reset
`default_nettype none

module mcd_top_sva (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // events and pin configuration
   input wire logic zero_cross_in,
   input wire logic demag_in,
   input wire mcd_pkg::mcd_pins_s pins,
   input wire mcd_pkg::mcd_events_s events
);
   // ********
   // sequences and properties
   // ********
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   // both write halves taken at one edge
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // high for exactly one cycle
   sequence s_pulse(sig);
      sig ##1 !sig;
   endsequence

   property p_wr_answer;
      s_wr_taken |-> ##2 s_axi_bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer)
      else $error("write response late");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped");
   property p_zero_pulse;
      zero_cross_in |=> s_pulse(events.zero);
   endproperty
   a_zero_pulse: assert property (p_zero_pulse)
      else $error("zero event not one pulse");
   property p_demag_pulse;
      demag_in |=> s_pulse(events.demag);
   endproperty
   a_demag_pulse: assert property (p_demag_pulse)
      else $error("demag event not one pulse");
   property p_comp_onehot;
      pins.comp_on |-> $onehot(pins.analog_sel) && pins.digital_sel == 3'h0;
   endproperty
   a_comp_onehot: assert property (p_comp_onehot)
      else $error("comparator without one analog input");
   property p_analog_no_port;
      (pins.analog_sel & (pins.read_en | pins.std_io)) == 3'h0;
   endproperty
   a_analog_no_port: assert property (p_analog_no_port)
      else $error("analog input still on port");
   property p_digital_read;
      (pins.digital_sel & ~pins.read_en) == 3'h0;
   endproperty
   a_digital_read: assert property (p_digital_read)
      else $error("digital input unreadable");
   property p_speed_no_comp;
      pins.speed_mode |-> !pins.comp_on && pins.analog_sel == 3'h0;
   endproperty
   a_speed_no_comp: assert property (p_speed_no_comp)
      else $error("comparator on in speed mode");
   property p_speed_no_comm;
      pins.speed_mode && $past(pins.speed_mode) |-> !events.comm;
   endproperty
   a_speed_no_comm: assert property (p_speed_no_comm)
      else $error("commutation in speed mode");
   // reset itself is checked
   property p_reset_quiet;
      disable iff (1'b0) reset |-> events == '0 && pins == '0;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs active during reset");
endmodule

bind mcd_top mcd_top_sva i_sva (
   .clock(clock),
   .reset(reset),
   .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .zero_cross_in(zero_cross_in),
   .demag_in(demag_in),
   .pins(pins),
   .events(events)
);

`default_nettype wire

// >>> verification/mcd_rotor_model.sv
// rotor position detection model: hands single-cycle event pulses over
// assumes the bench raises a request for one cycle per wanted event
`default_nettype none

module mcd_rotor_model (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // requests from the bench
   input wire logic fire_zero,
   input wire logic fire_demag,
   // detection pulses toward the block
   output logic zero_cross_in,
   output logic demag_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // registered so pulses move just after an edge, never on it
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         zero_cross_in <= 1'b0;
         demag_in <= 1'b0;
      end else begin
         zero_cross_in <= fire_zero;
         demag_in <= fire_demag;
      end
   end
endmodule

`default_nettype wire

// >>> verification/mcd_top_bench.sv
// self-checking bench for the delay manager: bus tasks and event stimulus
// assumes the checker binds itself and the rotor model makes the pulses
`default_nettype none

`define CHK(what, exp, got) \
   begin \
      check_count++; \
      if ((got) !== (exp)) begin \
         err_count++; \
         $display("mismatch %s expected %0h seen %0h", what, exp, got); \
      end \
   end

module mcd_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0, reset = 1'b0;
   logic [5:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, fz = 1'b0, fd = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, zc_in, dm_in;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, rdat;
   logic [5:0] phase;
   mcd_pkg::mcd_pins_s pins;
   mcd_pkg::mcd_events_s events;
   int err_count = 0, check_count = 0, cyc = 0;
   int comm_n = 0, comm_at = 0, comm_gap = 0;

   always #4 clock = ~clock;

   mcd_top i_dut (.clock(clock), .reset(reset),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .zero_cross_in(zc_in), .demag_in(dm_in),
      .pins(pins), .events(events), .phase_state(phase));

   mcd_rotor_model i_rotor (.clock(clock), .reset(reset), .fire_zero(fz),
      .fire_demag(fd), .zero_cross_in(zc_in), .demag_in(dm_in));

   // ********
   // bus and event tasks
   // ********
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clock);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      // ready lags valid a cycle so a held answer is exercised
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         bready <= bvalid && !bready;
      end while (!(bvalid && bready));
      resp = bresp;
   endtask

   task automatic rd(input logic [5:0] a);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
         rready <= rvalid && !rready;
      end while (!(rvalid && rready));
      rdat = rdata;
      resp = rresp;
   endtask

   task automatic pulse(input bit dem);
      @(posedge clock);
      if (dem) fd <= 1'b1;
      else fz <= 1'b1;
      @(posedge clock);
      fd <= 1'b0;
      fz <= 1'b0;
   endtask

   task automatic do_reset;
      reset <= 1'b1;
      repeat (10) @(posedge clock);
      reset <= 1'b0;
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // expected pin roles; analog inputs lose the port, digital and plain i/o ones keep it
   function automatic mcd_pkg::mcd_pins_s exp_pins(input logic [7:0] cfg);
      mcd_pkg::mcd_pins_s p;
      logic [2:0] one;
      p = '0;
      one = (cfg[5:4] == 2'h3) ? 3'h0 : 3'h1 << cfg[5:4];
      p.comp_on = (one != 3'h0) && cfg[2:1] == 2'h0;
      if (cfg[0] && cfg[2:1] == 2'h0) begin
         p.analog_sel = one;
         p.std_io = ~one;
      end else if (cfg[0]) begin
         p.digital_sel = (one == 3'h0) ? 3'h3 : one;
         p.std_io = ~p.digital_sel;
         p.speed_mode = 1'b1;
      end else begin
         p.analog_sel = one;
         p.ground_en = cfg[6] ? ~one : 3'h0;
      end
      p.read_en = p.std_io | p.digital_sel;
      return p;
   endfunction

   // commutation pulse count, spacing, and the hang limit
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (events.comm === 1'b1) begin
         comm_n <= comm_n + 1;
         comm_gap <= cyc - comm_at;
         comm_at <= cyc;
      end
      if (cyc == 30000) begin
         err_count++;
         conclude();
      end
   end

   // ********
   // test sequence
   // ********
   initial begin
      logic [7:0] cfg;
      logic [7:0] prev;
      logic [7:0] zc1;
      int n0;
      do_reset();
      // timer, captures and compare come up cleared
      for (int i = 9; i >= 4; i--) begin
         rd(6'(i * 4));
         `CHK("reset value", 32'h0000_0000, rdat)
      end
      rd(6'h2C);
      `CHK("unmapped read", mcd_pkg::RESP_SLVERR, resp)
      wr(6'h30, 8'h55);
      `CHK("unmapped write", mcd_pkg::RESP_SLVERR, resp)
      // pin table; the comparator is parked before the select moves
      prev = 8'h00;
      for (int c = 0; c < 64; c++) begin
         cfg = {1'b0, c[0], c[2:1], 1'b0, c[4:3], c[5]};
         if (!c[5] && (c[4:3] != 2'h0 || c[2:1] == 2'h3)) continue;
         wr(mcd_pkg::OFS_PIN, prev | 8'h02);
         wr(mcd_pkg::OFS_PIN, cfg);
         prev = cfg;
         repeat (3) @(posedge clock);
         `CHK("pins", exp_pins(cfg), pins)
      end
      // soft commutation needs a compare write, and fires once per write
      do_reset();
      wr(mcd_pkg::OFS_PIN, 8'h01);
      wr(mcd_pkg::OFS_MODE, 8'h04);
      wr(mcd_pkg::OFS_PIN, 8'h81);
      wr(mcd_pkg::OFS_PHASE, 8'h2A);
      n0 = comm_n;
      repeat (300) @(posedge clock);
      `CHK("soft comm unarmed", n0, comm_n)
      `CHK("phase held", 6'h00, phase)
      wr(mcd_pkg::OFS_COMP, 8'h0A);
      repeat (300) @(posedge clock);
      `CHK("soft comm once", n0 + 1, comm_n)
      `CHK("phase at comm", 6'h2A, phase)
      // switched mode at two prescaler ratios, compare value from software
      for (int r = 0; r < 2; r++) begin
         wr(mcd_pkg::OFS_PIN, 8'h01);
         wr(mcd_pkg::OFS_MODE, 8'h00);
         wr(mcd_pkg::OFS_RATIO, 8'(r));
         wr(mcd_pkg::OFS_COMP, 8'h06);
         wr(mcd_pkg::OFS_PIN, 8'h81);
         n0 = comm_n;
         while (comm_n < n0 + 2) @(posedge clock);
         `CHK("comm period", 6 << r, comm_gap)
      end
      // autoswitched: half weight on the current capture
      wr(mcd_pkg::OFS_PIN, 8'h01);
      wr(mcd_pkg::OFS_RATIO, 8'h00);
      wr(mcd_pkg::OFS_WGHT, 8'h80);
      wr(mcd_pkg::OFS_MODE, 8'h03);
      wr(mcd_pkg::OFS_PIN, 8'h81);
      pulse(1'b0);
      repeat (60) @(posedge clock);
      n0 = comm_n;
      pulse(1'b0);
      rd(mcd_pkg::OFS_ZC);
      zc1 = rdat[7:0];
      rd(mcd_pkg::OFS_COMP);
      `CHK("auto compare", {24'h00_0000, 1'b0, zc1[7:1]}, rdat)
      repeat (60) @(posedge clock);
      `CHK("auto comm", n0 + 1, comm_n)
      pulse(1'b0);
      rd(mcd_pkg::OFS_TIMER);
      `CHK("timer cleared", 1'b1, rdat < 32'h0000_0008)
      rd(mcd_pkg::OFS_ZPRV);
      `CHK("previous capture", {24'h00_0000, zc1}, rdat)
      pulse(1'b1);
      rd(mcd_pkg::OFS_DEMAG);
      `CHK("demag capture", 1'b1, rdat != 32'h0000_0000)
      conclude();
   end
endmodule

`default_nettype wire
